// [logic/exec_pkg.sv]
package exec_pkg;
  localparam logic [3:0] OPC_SUBB    = 4'h5;
  localparam logic [1:0] SUB_SUBB    = 2'h2;
  localparam logic [3:0] OPC_SWAP    = 4'h3;
  localparam logic [1:0] SUB_SWAP    = 2'h2;
  localparam logic [3:0] OPC_TEST    = 4'h6;
  localparam logic [2:0] SUB_TEST    = 3'h3;
  localparam logic [11:0] OPC_TBL    = 12'h000;
  localparam logic [1:0] TBL_RD      = 2'h2;
  localparam logic [1:0] TBL_WR      = 2'h3;
  localparam logic [1:0] PTR_NONE    = 2'h0;
  localparam logic [1:0] PTR_POSTINC = 2'h1;
  localparam logic [1:0] PTR_POSTDEC = 2'h2;
  localparam logic [1:0] PTR_PREINC  = 2'h3;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam int HOLD_AW = 3;
  typedef enum logic [1:0] {st_exec, st_tbl2, st_flush, st_flush2} state_type;
endpackage

// [logic/holding_mem.sv]
`timescale 1ns/100ps
module holding_mem #(
  parameter int AW = 3
) (
  input  wire logic          clk_sys_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [2**AW];
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// [logic/exec_unit.sv]
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Subtract with borrow, result by destination bit
// - Swap nibbles, flags untouched, one cycle
// - Table read over two cycles, four pointer modes
// - Pointer bit zero selects low or high byte
// - Table write into holding register, two cycles
// - Holding registers readable through a separate port
// - Zero test skips next instruction, flags kept
// - Bank bit picks access or selected bank
// - Indexed offset mode only when extended enabled
module exec_unit #(
  parameter int PTR_W = 22
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             instr_valid_i,
  input  wire logic [15:0]      instr_i,
  input  wire logic             next_two_word_i,
  input  wire logic             extended_set_config_bit_i,
  input  wire logic [7:0]       w_i,
  input  wire logic             carry_i,
  input  wire logic [3:0]       bank_select_register_i,
  input  wire logic [7:0]       fsr2_low_i,
  input  wire logic [7:0]       file_rdata_i,
  input  wire logic [15:0]      prog_word_i,
  output logic                  busy_o,
  output logic                  discard_fetch_o,
  output logic [11:0]           file_addr_o,
  output logic                  file_we_o,
  output logic [7:0]            file_wdata_o,
  output logic                  w_we_o,
  output logic [7:0]            w_wdata_o,
  output logic                  flags_we_o,
  output logic [4:0]            flags_o,
  output logic [PTR_W-1:0]      prog_addr_o,
  output logic [PTR_W-1:0]      table_pointer_o,
  output logic [7:0]            table_latch_o,
  input  wire logic [exec_pkg::HOLD_AW-1:0] hold_raddr_i,
  output logic [7:0]            hold_rdata_o
);
  exec_pkg::state_type state_q;
  logic [PTR_W-1:0] ptr_q;
  logic [PTR_W-1:0] ptr_d;
  logic [7:0]       latch_q;
  logic [1:0]       mode_q;
  logic             is_rd_q;
  logic             hold_we;
  logic [7:0]       res;
  logic [8:0]       diff;
  logic             hc;
  logic             dst;
  logic             is_subb;
  logic             is_swap;
  logic             is_test;
  logic             is_tbl;
  logic             go;

  function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a, input logic [3:0] bank,
                                           input logic extended_set_config_bit, input logic [7:0] fsr2);
    logic [7:0] s;
    s = 8'h00;
    if (a) begin
      eff_addr = {bank, f};
    end else if (extended_set_config_bit && (f < exec_pkg::ACCESS_SPLIT)) begin
      s = fsr2 + f;
      eff_addr = {4'h0, s};
    end else if (f < exec_pkg::ACCESS_SPLIT) begin
      eff_addr = {4'h0, f};
    end else begin
      eff_addr = {exec_pkg::ACCESS_HIGH_BANK, f};
    end
  endfunction

  function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic [1:0] m, input logic pre);
    step_ptr = p;
    if (pre && m == exec_pkg::PTR_PREINC) begin
      step_ptr = p + 1'b1;
    end else if (!pre && m == exec_pkg::PTR_POSTINC) begin
      step_ptr = p + 1'b1;
    end else if (!pre && m == exec_pkg::PTR_POSTDEC) begin
      step_ptr = p - 1'b1;
    end
  endfunction

  // Strobes are gated by the enable too, so a frozen core never sees a write.
  assign go      = ce_i && instr_valid_i && state_q == exec_pkg::st_exec;
  assign is_subb = instr_i[15:12] == exec_pkg::OPC_SUBB && instr_i[11:10] == exec_pkg::SUB_SUBB;
  assign is_swap = instr_i[15:12] == exec_pkg::OPC_SWAP && instr_i[11:10] == exec_pkg::SUB_SWAP;
  assign is_test = instr_i[15:12] == exec_pkg::OPC_TEST && instr_i[11:9] == exec_pkg::SUB_TEST;
  assign is_tbl  = instr_i[15:4] == exec_pkg::OPC_TBL && instr_i[3];
  assign dst     = instr_i[9];
  assign file_addr_o = eff_addr(instr_i[7:0], instr_i[8], bank_select_register_i,
                                extended_set_config_bit_i, fsr2_low_i);

  always_comb begin
    diff = {1'b0, file_rdata_i} - {1'b0, w_i} - {8'h00, ~carry_i};
    hc   = {1'b0, file_rdata_i[3:0]} < ({1'b0, w_i[3:0]} + {4'h0, ~carry_i});
    res  = is_subb ? diff[7:0] : {file_rdata_i[3:0], file_rdata_i[7:4]};
  end

  assign w_we_o       = go && (is_subb || is_swap) && !dst;
  assign file_we_o    = go && (is_subb || is_swap) && dst;
  assign w_wdata_o    = res;
  assign file_wdata_o = res;
  assign flags_we_o   = go && is_subb;
  // Flags order: N, OV, Z, DC, C; C and DC are not-borrow.
  assign flags_o = {diff[7], (file_rdata_i[7] ^ w_i[7]) & (file_rdata_i[7] ^ diff[7]),
                    diff[7:0] == 8'h00, ~hc, ~diff[8]};

  // The fetched word is dropped combinationally so the core never executes it.
  assign discard_fetch_o = go && is_test && file_rdata_i == 8'h00;
  assign busy_o = state_q != exec_pkg::st_exec;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q <= exec_pkg::st_exec;
    end else if (ce_i) begin
      case (state_q)
        exec_pkg::st_exec: begin
          if (go && is_tbl) begin
            state_q <= exec_pkg::st_tbl2;
          end else if (discard_fetch_o) begin
            state_q <= next_two_word_i ? exec_pkg::st_flush2 : exec_pkg::st_flush;
          end
        end
        exec_pkg::st_flush2: state_q <= exec_pkg::st_flush;
        default: state_q <= exec_pkg::st_exec;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_q  <= exec_pkg::PTR_NONE;
      is_rd_q <= 1'b0;
    end else if (ce_i && go && is_tbl) begin
      mode_q  <= instr_i[1:0];
      is_rd_q <= instr_i[3:2] == exec_pkg::TBL_RD;
    end
  end

  always_comb begin
    ptr_d = ptr_q;
    if (go && is_tbl) begin
      ptr_d = step_ptr(ptr_q, instr_i[1:0], 1'b1);
    end else if (state_q == exec_pkg::st_tbl2) begin
      ptr_d = step_ptr(ptr_q, mode_q, 1'b0);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ptr_q <= '0;
    end else if (ce_i) begin
      ptr_q <= ptr_d;
    end
  end

  // Word address to memory; the byte lane is picked from pointer bit zero.
  assign prog_addr_o = {1'b0, ptr_q[PTR_W-1:1]};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      latch_q <= 8'h00;
    end else if (ce_i && state_q == exec_pkg::st_tbl2 && is_rd_q) begin
      latch_q <= ptr_q[0] ? prog_word_i[15:8] : prog_word_i[7:0];
    end
  end

  assign hold_we = state_q == exec_pkg::st_tbl2 && !is_rd_q;

  // Holding contents can be read through the hold_raddr_i / hold_rdata_o port, one cycle after the address and only while the enable is high.
  holding_mem #(
    .AW(exec_pkg::HOLD_AW)
  ) u_hold (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .we_i      (hold_we),
    .waddr_i   (ptr_q[exec_pkg::HOLD_AW-1:0]),
    .wdata_i   (latch_q),
    .raddr_i   (hold_raddr_i),
    .rdata_o   (hold_rdata_o)
  );

  assign table_pointer_o = ptr_q;
  assign table_latch_o   = latch_q;
endmodule

// [tb/far_side.sv]
`timescale 1ns/100ps
module far_side (
  input  wire logic        clk_sys_i,
  input  wire logic [11:0] fa_i,
  input  wire logic        fwe_i,
  input  wire logic [7:0]  fwd_i,
  input  wire logic [21:0] pa_i,
  output logic      [7:0]  frd_o,
  output logic      [15:0] pw_o
);
  logic [7:0] m [4096];
  // Flash bytes differ by half and across any 256 consecutive words, so a wrong byte select shows.
  assign pw_o  = {pa_i[7:0] ^ 8'ha5, pa_i[7:0]};
  assign frd_o = m[fa_i];
  always @(posedge clk_sys_i) if (fwe_i) m[fa_i] <= fwd_i;
endmodule

// [tb/exec_unit_monitor.sv]
`timescale 1ns/100ps
module exec_unit_monitor (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic        next_two_word_i,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        busy_o,
  input wire logic        discard_fetch_o,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  input wire logic        flags_we_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire tk = ce_i && instr_valid_i && !busy_o;
  wire sw = tk && instr_i[15:10] == 6'h0e;
  wire ts = tk && instr_i[15:9] == 7'h33;
  wire tb = tk && instr_i[15:4] == 12'h000 && instr_i[3];
  swap_flags_a: assert property (sw |-> !flags_we_o) else $error("swap flags");
  swap_value_a: assert property (sw && instr_i[9] |->
    file_we_o && file_wdata_o == {file_rdata_i[3:0], file_rdata_i[7:4]}) else $error("swap value");
  swap_dest_a: assert property (sw && !instr_i[9] |-> !file_we_o) else $error("swap dest");
  test_keep_a: assert property (ts |-> !flags_we_o && !file_we_o) else $error("test wrote");
  skip_flush_a: assert property (ts |-> discard_fetch_o == (file_rdata_i == 8'h00)) else $error("discard");
  skip_one_a: assert property (ts && file_rdata_i == 8'h00 && !next_two_word_i |=> busy_o ##1 !busy_o)
    else $error("skip length");
  skip_two_a: assert property (ts && file_rdata_i == 8'h00 && next_two_word_i |=> busy_o [*2] ##1 !busy_o)
    else $error("long skip");
  table_two_a: assert property (tb |=> busy_o ##1 !busy_o) else $error("table length");
  cover property (sw);
  cover property (ts && next_two_word_i && file_rdata_i == 8'h00);
  cover property (tb);
endmodule
bind exec_unit exec_unit_monitor u_mon (
  .clk_sys_i       (clk_sys_i),
  .reset_i         (reset_i),
  .ce_i            (ce_i),
  .instr_valid_i   (instr_valid_i),
  .instr_i         (instr_i),
  .next_two_word_i (next_two_word_i),
  .file_rdata_i    (file_rdata_i),
  .busy_o          (busy_o),
  .discard_fetch_o (discard_fetch_o),
  .file_we_o       (file_we_o),
  .file_wdata_o    (file_wdata_o),
  .flags_we_o      (flags_we_o)
);

// [tb/subtract_swap_table_skip_ops_test.sv]
`timescale 1ns/100ps
module subtract_swap_table_skip_ops_test;
  logic clk_sys_i = 0, reset_i = 1, instr_valid_i = 0, two_i = 0, carry_i = 0, dsc;
  logic ce_i = 1, xi = 0;
  logic [5:0] flg;
  wire flwe;
  wire [4:0] fl;
  logic [15:0] instr_i = 0;
  logic [7:0] w_i = 0, wcap;
  logic [2:0] hra = 0;
  int fail_count = 0, n_checks = 0, n;
  wire busy_o, disc_o, fwe, wwe;
  wire [7:0] frd, fwd, wwd, lat, hrd;
  wire [11:0] fa;
  wire [15:0] pw;
  wire [21:0] pa, ptr;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (wwe) wcap <= wwd;
  exec_unit u_dut (.clk_sys_i, .reset_i, .ce_i, .instr_valid_i, .instr_i, .next_two_word_i(two_i),
    .extended_set_config_bit_i(xi), .w_i, .carry_i, .bank_select_register_i(4'h1), .fsr2_low_i(8'h40),
    .file_rdata_i(frd), .prog_word_i(pw), .busy_o, .discard_fetch_o(disc_o), .file_addr_o(fa), .file_we_o(fwe),
    .file_wdata_o(fwd), .w_we_o(wwe), .w_wdata_o(wwd), .flags_we_o(flwe), .flags_o(fl), .prog_addr_o(pa),
    .table_pointer_o(ptr), .table_latch_o(lat), .hold_raddr_i(hra), .hold_rdata_o(hrd));
  far_side u_far (.clk_sys_i, .fa_i(fa), .fwe_i(fwe), .fwd_i(fwd), .pa_i(pa), .frd_o(frd), .pw_o(pw));
  task summarize;
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [23:0] g, e);
    n_checks++;
    if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
    fail_count += g !== e;
  endtask
  task run(input logic [15:0] op, input int c);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'h1;
    instr_i <= op;
    #1 dsc = disc_o;
    flg = {flwe, fl};
    @(posedge clk_sys_i);
    instr_valid_i <= 1'h0;
    #1 for (n = 0; busy_o === 1'b1 && n < 9; n++) @(posedge clk_sys_i) #1;
    chk(n, c);
    if (n == 9) summarize;
  endtask
  task fop(input logic [15:0] op, input logic [7:0] f, input logic [10:0] w, input int cy, input logic [7:0] e);
    logic [11:0] a;
    a = {op[8] ? 4'h1 : {4{op[7:0] > 8'h5f}}, op[7:0]};
    if (w[10] && !op[8] && op[7:0] < 8'h60) a = {4'h0, op[7:0] + 8'h40};
    @(posedge clk_sys_i);
    u_far.m[a] = f;
    {xi, two_i, carry_i, w_i} <= w;
    run(op, cy);
    chk(op[9] ? u_far.m[a] : wcap, e);
    chk(dsc, op[15:12] == 4'h6 && f == 8'h00);
  endtask
  task tbl;
    logic [21:0] p;
    logic [7:0] b;
    p = 0;
    for (int k = 0; k < 9; k++) begin
      p += k % 4 == 3;
      if (k < 4 || k > 7) b = p[0] ? p[8:1] ^ 8'ha5 : p[8:1];
      @(posedge clk_sys_i);
      hra <= p[2:0];
      p += (k % 4 == 1) - (k % 4 == 2);
      run(16'h0008 + k % 8, 1);
      chk(ptr, p);
      @(posedge clk_sys_i) #1;
      chk(k > 3 && k < 8 ? hrd : lat, b);
    end
  endtask
  // A table read issued while the enable is low must leave the pointer and state alone.
  task freeze;
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    instr_valid_i <= 1'b1;
    instr_i <= 16'h0009;
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    instr_valid_i <= 1'b0;
    #1 chk({busy_o, ptr}, {1'b0, 22'h2});
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'h0;
    fop(16'h5b23, 8'h19, 10'h10d, 0, 8'h0c);
    chk(flg, 6'h21);
    fop(16'h5923, 8'h1b, 10'h01a, 0, 8'h00);
    chk(flg, 6'h27);
    fop(16'h5b23, 8'h03, 10'h10e, 0, 8'hf5);
    chk(flg, 6'h30);
    fop(16'h3a70, 8'h5a, 10'h000, 0, 8'ha5);
    fop(16'h3820, 8'h3c, 10'h000, 0, 8'hc3);
    fop(16'h3820, 8'h3c, 11'h400, 0, 8'hc3);
    fop(16'h6723, 8'h00, 10'h000, 1, 8'h00);
    fop(16'h6723, 8'h00, 10'h200, 2, 8'h00);
    fop(16'h6723, 8'h07, 10'h200, 0, 8'h07);
    tbl;
    freeze;
    summarize;
  end
endmodule
